// >>> r14d_core.sv
// Decode and execute core for 14-bit instruction words.
`timescale 1ns/100ps
`default_nettype none
module r14d_core #(
  parameter logic [6:0] TIMER_ADDR = 7'h01, // Timer register address
  parameter logic [6:0] PORT_ADDR = 7'h06 // Address read from the pins
) (
  input wire logic mclk, // Oscillator clock, 40 MHz
  input wire logic resetn, // Synchronous reset, active low
  output logic [r14d_pkg::PC_W-1:0] prog_addr, // Program address
  input wire logic [r14d_pkg::IW-1:0] prog_word, // Instruction word
  output logic [r14d_pkg::FA_W-1:0] file_addr, // File address
  input wire logic [r14d_pkg::DW-1:0] file_rdata, // File read data
  output logic [r14d_pkg::DW-1:0] file_wdata, // File write data
  output logic file_we, // File write strobe
  input wire logic [r14d_pkg::DW-1:0] port_pins, // Port pin levels
  input wire logic presc_on_timer, // Prescaler assigned to timer
  output logic presc_clear, // Prescaler clear pulse
  output logic wdt_clear, // Watchdog clear pulse
  input wire logic wake, // Leave standby
  output logic standby, // Core in standby
  output logic [r14d_pkg::DW-1:0] main_accumulator, // Accumulator
  output logic ninth_bit_flag, // Carry flag
  output logic digit_carry, // Digit carry flag
  output logic result_null_flag, // Zero flag
  output logic expiry_flag, // Time-out flag
  output logic powerdown_flag // Power-down flag
);
  import r14d_pkg::*;
  r14d_phase_t ph_q;
  r14d_alu_op_t op;
  logic [IW-1:0] ir_q;
  logic [PC_W-1:0] pc_q, pc_inc, pc_skp, jtgt;
  logic [FA_W-1:0] fa_q;
  logic [DW-1:0] opnd_q, w_q, wdat_q, pins_s, alu_b, res;
  logic [PC_W-1:0] stk_q [STACK_DEPTH];
  logic [SP_W-1:0] sp_q;
  logic we_q, c_q, dc_q, z_q, to_q, pwrdn_q, stby_q, flush_q, pclr_q, wclr_q;
  logic use_lit, wr_f, wr_w, upd_c, upd_dc, upd_z;
  logic sk_zero, sk_clr, sk_set, is_call, is_branch_instr, is_ret, is_sleep, is_wdt;
  logic alu_c, alu_dc, tbit, skip, exec, tmr_w, res_zero;

  always_comb begin
    op = ALU_PASSB;
    use_lit = 1'b0;
    wr_f = 1'b0;
    wr_w = 1'b0;
    upd_c = 1'b0;
    upd_dc = 1'b0;
    upd_z = 1'b0;
    sk_zero = 1'b0;
    sk_clr = 1'b0;
    sk_set = 1'b0;
    is_call = 1'b0;
    is_branch_instr = 1'b0;
    is_ret = 1'b0;
    is_sleep = 1'b0;
    is_wdt = 1'b0;
    case (ir_q[CLS_HI:CLS_LO])
      CLS_BYTE: begin
        wr_f = ir_q[DEST_BIT];
        wr_w = !ir_q[DEST_BIT];
        case (ir_q[OP_HI:OP_LO])
          OPB_MISC: begin
            // With the destination bit set this stores the accumulator.
            op = ALU_PASSA;
            wr_w = 1'b0;
            if (!ir_q[DEST_BIT]) begin
              case (ir_q[FA_HI:0])
                MISC_RETURN, MISC_RETINT: is_ret = 1'b1;
                MISC_SLEEP: is_sleep = 1'b1;
                MISC_DOGCLR: is_wdt = 1'b1;
                default: is_ret = 1'b0;
              endcase
            end
          end
          OPB_CLR: begin
            op = ALU_ZERO;
            upd_z = 1'b1;
          end
          OPB_SUB: begin
            op = ALU_SUB;
            {upd_c, upd_dc, upd_z} = 3'h7;
          end
          OPB_DEC: begin
            op = ALU_DEC;
            upd_z = 1'b1;
          end
          OPB_IOR: begin
            op = ALU_IOR;
            upd_z = 1'b1;
          end
          OPB_AND: begin
            op = ALU_AND;
            upd_z = 1'b1;
          end
          OPB_XOR: begin
            op = ALU_XOR;
            upd_z = 1'b1;
          end
          OPB_ADD: begin
            op = ALU_ADD;
            {upd_c, upd_dc, upd_z} = 3'h7;
          end
          OPB_MOV: upd_z = 1'b1;
          OPB_COM: begin
            op = ALU_COM;
            upd_z = 1'b1;
          end
          OPB_INC: begin
            op = ALU_INC;
            upd_z = 1'b1;
          end
          OPB_DECSZ: begin
            op = ALU_DEC;
            sk_zero = 1'b1;
          end
          OPB_RR: begin
            op = ALU_RR;
            upd_c = 1'b1;
          end
          OPB_RL: begin
            op = ALU_RL;
            upd_c = 1'b1;
          end
          OPB_SWAP: op = ALU_SWAP;
          OPB_INCSZ: begin
            op = ALU_INC;
            sk_zero = 1'b1;
          end
          default: op = ALU_PASSB;
        endcase
      end
      CLS_BIT: begin
        case (ir_q[BOP_HI:BOP_LO])
          BOP_CLR: begin
            op = ALU_BCLR;
            wr_f = 1'b1;
          end
          BOP_SET: begin
            op = ALU_BSET;
            wr_f = 1'b1;
          end
          BOP_TSTC: sk_clr = 1'b1;
          BOP_TSTS: sk_set = 1'b1;
          default: sk_set = 1'b0;
        endcase
      end
      CLS_JUMP: begin
        is_branch_instr = ir_q[JMP_SEL];
        is_call = !ir_q[JMP_SEL];
      end
      CLS_LIT: begin
        use_lit = 1'b1;
        wr_w = 1'b1;
        case (ir_q[OP_HI:OPL_GRP_LO])
          OPL_MOV: op = ALU_PASSB;
          OPL_RET: is_ret = 1'b1;
          OPL_LOGIC: begin
            case (ir_q[OP_HI:OP_LO])
              OPL_IOR: begin
                op = ALU_IOR;
                upd_z = 1'b1;
              end
              OPL_AND: begin
                op = ALU_AND;
                upd_z = 1'b1;
              end
              OPL_XOR: begin
                op = ALU_XOR;
                upd_z = 1'b1;
              end
              default: wr_w = 1'b0;
            endcase
          end
          default: begin
            {upd_c, upd_dc, upd_z} = 3'h7;
            case (ir_q[OP_HI:OPL_AR_LO])
              OPL_SUB: op = ALU_SUB;
              OPL_ADD: op = ALU_ADD;
              default: op = ALU_PASSB;
            endcase
          end
        endcase
      end
      default: wr_w = 1'b0;
    endcase
  end

  assign alu_b = use_lit ? ir_q[DW-1:0] : opnd_q;

  r14d_alu u_alu (
    .op(op),
    .a(w_q),
    .b(alu_b),
    .cin(c_q),
    .bsel(ir_q[BIT_HI:BIT_LO]),
    .res(res),
    .cout(alu_c),
    .dcout(alu_dc)
  );

  r14d_sync #(.W(DW)) u_sync (
    .mclk(mclk),
    .resetn(resetn),
    .din(port_pins),
    .dout(pins_s)
  );

  assign res_zero = (res == '0);
  assign tbit = opnd_q[ir_q[BIT_HI:BIT_LO]];
  assign skip = (sk_zero && res_zero) || (sk_clr && !tbit)
    || (sk_set && tbit);
  assign exec = (ph_q == PH_Q4) && !stby_q && !flush_q;
  assign tmr_w = wr_f && (ir_q[FA_HI:0] == TIMER_ADDR);
  assign pc_inc = pc_q + 1'b1;
  assign pc_skp = pc_q + PC_SKIP;
  assign jtgt = {pc_q[PC_W-1:JMP_K_W], ir_q[JMP_K_W-1:0]};

  // Four phases per instruction cycle; execution lands on the last one.
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      ph_q <= PH_Q1;
    end else begin
      case (ph_q)
        PH_Q1: ph_q <= PH_Q2;
        PH_Q2: ph_q <= PH_Q3;
        PH_Q3: ph_q <= PH_Q4;
        PH_Q4: ph_q <= PH_Q1;
        default: ph_q <= PH_Q1;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      ir_q <= IR_RST;
      fa_q <= '0;
      opnd_q <= '0;
    end else begin
      if (ph_q == PH_Q1) begin
        ir_q <= prog_word;
      end
      if (ph_q == PH_Q2) begin
        fa_q <= ir_q[FA_HI:0];
      end
      if (ph_q == PH_Q3) begin
        opnd_q <= (fa_q == PORT_ADDR) ? pins_s : file_rdata;
      end
    end
  end

  // Program counter and return stack; the stack wraps when it overflows.
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      pc_q <= PC_RST;
      sp_q <= '0;
    end else if (exec) begin
      if (is_call) begin
        stk_q[sp_q] <= pc_inc;
        sp_q <= sp_q + 1'b1;
        pc_q <= jtgt;
      end else if (is_branch_instr) begin
        pc_q <= jtgt;
      end else if (is_ret) begin
        sp_q <= sp_q - 1'b1;
        pc_q <= stk_q[sp_q - 1'b1];
      end else if (skip) begin
        pc_q <= pc_skp;
      end else begin
        pc_q <= pc_inc;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      flush_q <= 1'b0;
    end else if (exec) begin
      flush_q <= skip || is_call || is_branch_instr || is_ret;
    end else if (ph_q == PH_Q4 && !stby_q) begin
      flush_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      w_q <= '0;
      we_q <= 1'b0;
      wdat_q <= '0;
      pclr_q <= 1'b0;
    end else begin
      we_q <= exec && wr_f;
      pclr_q <= exec && tmr_w && presc_on_timer;
      if (exec && wr_f) begin
        wdat_q <= res;
      end
      if (exec && wr_w) begin
        w_q <= res;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      c_q <= 1'b0;
      dc_q <= 1'b0;
      z_q <= 1'b0;
    end else if (exec) begin
      if (upd_c) begin
        c_q <= alu_c;
      end
      if (upd_dc) begin
        dc_q <= alu_dc;
      end
      if (upd_z) begin
        z_q <= res_zero;
      end
    end
  end

  // Standby entry wins over a wake request in the same clock.
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      to_q <= TO_RST;
      pwrdn_q <= PWRDN_RST;
      stby_q <= 1'b0;
      wclr_q <= 1'b0;
    end else begin
      wclr_q <= exec && (is_sleep || is_wdt);
      if (exec && is_sleep) begin
        to_q <= 1'b1;
        pwrdn_q <= 1'b0;
        stby_q <= 1'b1;
      end else begin
        if (exec && is_wdt) begin
          to_q <= 1'b1;
          pwrdn_q <= 1'b1;
        end
        if (wake) begin
          stby_q <= 1'b0;
        end
      end
    end
  end

  assign prog_addr = pc_q;
  assign file_addr = fa_q;
  assign file_wdata = wdat_q;
  assign file_we = we_q;
  assign presc_clear = pclr_q;
  assign wdt_clear = wclr_q;
  assign standby = stby_q;
  assign main_accumulator = w_q;
  assign ninth_bit_flag = c_q;
  assign digit_carry = dc_q;
  assign result_null_flag = z_q;
  assign expiry_flag = to_q;
  assign powerdown_flag = pwrdn_q;

  a_cycle_len: assert property (@(posedge mclk)
    disable iff (!resetn)
    (ph_q == PH_Q4) |=> (ph_q != PH_Q4) [*3] ##1 (ph_q == PH_Q4))
    else $error("Instruction cycle is not four clocks");
  a_flush_idle: assert property (@(posedge mclk)
    disable iff (!resetn)
    (ph_q == PH_Q4 && flush_q && !stby_q)
      |=> !we_q && $stable(w_q) && $stable(pc_q) && !flush_q)
    else $error("Second cycle had an effect");
  a_jump_two: assert property (@(posedge mclk)
    disable iff (!resetn)
    (exec && (is_call || is_branch_instr)) |=> flush_q && pc_q == $past(jtgt))
    else $error("Jump target or second cycle wrong");
  a_skip_zero: assert property (@(posedge mclk)
    disable iff (!resetn)
    (exec && sk_zero && res_zero) |=> flush_q && pc_q == $past(pc_skp)
      && $stable({c_q, dc_q, z_q}))
    else $error("Zero skip wrong");
  a_tst_clear: assert property (@(posedge mclk)
    disable iff (!resetn)
    (exec && sk_clr) |=> flush_q == !opnd_q[$past(ir_q[BIT_HI:BIT_LO])]
      && $stable(z_q))
    else $error("Clear bit test skip wrong");
  a_tst_set: assert property (@(posedge mclk)
    disable iff (!resetn)
    (exec && sk_set) |=> flush_q == $past(tbit) && !we_q)
    else $error("Set bit test skip wrong");
  a_rot_left: assert property (@(posedge mclk)
    disable iff (!resetn)
    (exec && op == ALU_RL) |=> c_q == opnd_q[DW-1] && $stable(z_q))
    else $error("Rotate left carry wrong");
  a_rot_right: assert property (@(posedge mclk)
    disable iff (!resetn)
    (exec && op == ALU_RR) |=> c_q == opnd_q[0]
      && (we_q || w_q == {$past(c_q), opnd_q[DW-1:1]}))
    else $error("Rotate right result wrong");
  a_xor_file: assert property (@(posedge mclk)
    disable iff (!resetn)
    (exec && op == ALU_XOR && !use_lit)
      |=> z_q == ($past(w_q) == opnd_q) && $stable(c_q))
    else $error("Exclusive OR zero flag wrong");
  a_sleep_flags: assert property (@(posedge mclk)
    disable iff (!resetn)
    (exec && is_sleep) |=> stby_q && to_q && !pwrdn_q && wclr_q)
    else $error("Standby entry wrong");
  a_tmr_clear: assert property (@(posedge mclk)
    disable iff (!resetn)
    (exec && tmr_w && presc_on_timer) |=> pclr_q && we_q)
    else $error("Prescaler not cleared");
  a_dest_acc: assert property (@(posedge mclk)
    disable iff (!resetn)
    (exec && ir_q[CLS_HI:CLS_LO] == CLS_BYTE && !ir_q[DEST_BIT])
      |=> !we_q)
    else $error("Accumulator result written to file");
  a_pin_operand: assert property (@(posedge mclk)
    disable iff (!resetn)
    (ph_q == PH_Q3 && fa_q == PORT_ADDR) |=> opnd_q == $past(pins_s))
    else $error("Port operand not from pins");
endmodule
`default_nettype wire

// >>> r14d_pkg.sv
// Shared constants and types of the 14-bit instruction core.
package r14d_pkg;
  localparam int PC_W = 13;
  localparam int IW = 14;
  localparam int DW = 8;
  localparam int NIB_W = 4;
  localparam int FA_W = 7;
  localparam int BIT_W = 3;
  localparam int JMP_K_W = 11;
  localparam int STACK_DEPTH = 8;
  localparam int SP_W = 3;
  localparam int OSC_PER_CYCLE = 4;
  localparam int CLS_HI = 13;
  localparam int CLS_LO = 12;
  localparam int OP_HI = 11;
  localparam int OP_LO = 8;
  localparam int BOP_HI = 11;
  localparam int BOP_LO = 10;
  localparam int JMP_SEL = 11;
  localparam int DEST_BIT = 7;
  localparam int BIT_HI = 9;
  localparam int BIT_LO = 7;
  localparam int FA_HI = 6;
  localparam logic [1:0] CLS_BYTE = 2'h0;
  localparam logic [1:0] CLS_BIT = 2'h1;
  localparam logic [1:0] CLS_JUMP = 2'h2;
  localparam logic [1:0] CLS_LIT = 2'h3;
  localparam logic [3:0] OPB_MISC = 4'h0;
  localparam logic [3:0] OPB_CLR = 4'h1;
  localparam logic [3:0] OPB_SUB = 4'h2;
  localparam logic [3:0] OPB_DEC = 4'h3;
  localparam logic [3:0] OPB_IOR = 4'h4;
  localparam logic [3:0] OPB_AND = 4'h5;
  localparam logic [3:0] OPB_XOR = 4'h6;
  localparam logic [3:0] OPB_ADD = 4'h7;
  localparam logic [3:0] OPB_MOV = 4'h8;
  localparam logic [3:0] OPB_COM = 4'h9;
  localparam logic [3:0] OPB_INC = 4'ha;
  localparam logic [3:0] OPB_DECSZ = 4'hb;
  localparam logic [3:0] OPB_RR = 4'hc;
  localparam logic [3:0] OPB_RL = 4'hd;
  localparam logic [3:0] OPB_SWAP = 4'he;
  localparam logic [3:0] OPB_INCSZ = 4'hf;
  localparam logic [1:0] BOP_CLR = 2'h0;
  localparam logic [1:0] BOP_SET = 2'h1;
  localparam logic [1:0] BOP_TSTC = 2'h2;
  localparam logic [1:0] BOP_TSTS = 2'h3;
  localparam int OPL_GRP_LO = 10;
  localparam int OPL_AR_LO = 9;
  localparam logic [1:0] OPL_MOV = 2'h0;
  localparam logic [1:0] OPL_RET = 2'h1;
  localparam logic [1:0] OPL_LOGIC = 2'h2;
  localparam logic [3:0] OPL_IOR = 4'h8;
  localparam logic [3:0] OPL_AND = 4'h9;
  localparam logic [3:0] OPL_XOR = 4'ha;
  localparam logic [2:0] OPL_SUB = 3'h6;
  localparam logic [2:0] OPL_ADD = 3'h7;
  localparam logic [6:0] MISC_RETURN = 7'h08;
  localparam logic [6:0] MISC_RETINT = 7'h09;
  localparam logic [6:0] MISC_SLEEP = 7'h63;
  localparam logic [6:0] MISC_DOGCLR = 7'h64;
  localparam logic [IW-1:0] IR_RST = 14'h0000;
  localparam logic [PC_W-1:0] PC_RST = 13'h0000;
  localparam logic [PC_W-1:0] PC_SKIP = 13'h0002;
  localparam logic TO_RST = 1'b1;
  localparam logic PWRDN_RST = 1'b1;
  typedef enum logic [1:0] {
    PH_Q1 = 2'h0, PH_Q2 = 2'h1, PH_Q3 = 2'h3, PH_Q4 = 2'h2
  } r14d_phase_t;
  typedef enum logic [3:0] {
    ALU_ADD, ALU_SUB, ALU_AND, ALU_IOR, ALU_XOR, ALU_COM, ALU_DEC, ALU_INC,
    ALU_PASSA, ALU_PASSB, ALU_RL, ALU_RR, ALU_SWAP, ALU_ZERO, ALU_BCLR,
    ALU_BSET
  } r14d_alu_op_t;
endpackage

// >>> r14d_alu.sv
// Arithmetic and logic unit of the instruction core.
`timescale 1ns/100ps
`default_nettype none
module r14d_alu (
  input wire r14d_pkg::r14d_alu_op_t op, // Operation
  input wire logic [r14d_pkg::DW-1:0] a, // Accumulator
  input wire logic [r14d_pkg::DW-1:0] b, // File operand or literal
  input wire logic cin, // Carry in
  input wire logic [r14d_pkg::BIT_W-1:0] bsel, // Bit number
  output logic [r14d_pkg::DW-1:0] res, // Result
  output logic cout, // Carry out
  output logic dcout // Digit carry out
);
  import r14d_pkg::*;
  logic [DW:0] sum;
  logic [NIB_W:0] nib;
  always_comb begin
    sum = '0;
    nib = '0;
    res = b;
    cout = cin;
    dcout = 1'b0;
    case (op)
      ALU_ADD: begin
        sum = {1'b0, a} + {1'b0, b};
        nib = {1'b0, a[NIB_W-1:0]} + {1'b0, b[NIB_W-1:0]};
      end
      ALU_SUB: begin
        // Carry and digit carry read as no borrow.
        sum = {1'b0, b} + {1'b0, ~a} + {{DW{1'b0}}, 1'b1};
        nib = {1'b0, b[NIB_W-1:0]} + {1'b0, ~a[NIB_W-1:0]}
          + {{NIB_W{1'b0}}, 1'b1};
      end
      ALU_AND: res = a & b;
      ALU_IOR: res = a | b;
      ALU_XOR: res = a ^ b;
      ALU_COM: res = ~b;
      ALU_DEC: res = b - 1'b1;
      ALU_INC: res = b + 1'b1;
      ALU_PASSA: res = a;
      ALU_RL: begin
        res = {b[DW-2:0], cin};
        cout = b[DW-1];
      end
      ALU_RR: begin
        res = {cin, b[DW-1:1]};
        cout = b[0];
      end
      ALU_SWAP: res = {b[NIB_W-1:0], b[DW-1:NIB_W]};
      ALU_ZERO: res = '0;
      ALU_BCLR: res[bsel] = 1'b0;
      ALU_BSET: res[bsel] = 1'b1;
      default: res = b;
    endcase
    if (op == ALU_ADD || op == ALU_SUB) begin
      res = sum[DW-1:0];
      cout = sum[DW];
      dcout = nib[NIB_W];
    end
  end
endmodule
`default_nettype wire

// >>> r14d_sync.sv
// Three-stage pin synchroniser that accepts a change once two stages agree.
`timescale 1ns/100ps
`default_nettype none
module r14d_sync #(
  parameter int W = 8 // Number of pins
) (
  input wire logic mclk, // Core clock
  input wire logic resetn, // Synchronous reset, active low
  input wire logic [W-1:0] din, // Asynchronous pin levels
  output logic [W-1:0] dout // Filtered pin levels
);
  logic [W-1:0] s1_q, s2_q, s3_q, out_q;
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      out_q <= '0;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int i = 0; i < W; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          out_q[i] <= s3_q[i];
        end
      end
    end
  end
  assign dout = out_q;
endmodule
`default_nettype wire

// >>> r14d_mem_model.sv
// Program memory and data file model that faces the instruction core.
`timescale 1ns/100ps
`default_nettype none
module r14d_mem_model (
  input wire logic mclk, // Core clock
  input wire logic [r14d_pkg::PC_W-1:0] prog_addr, // Program address
  output logic [r14d_pkg::IW-1:0] prog_word, // Instruction word
  input wire logic [r14d_pkg::FA_W-1:0] file_addr, // File address
  output logic [r14d_pkg::DW-1:0] file_rdata, // File read data
  input wire logic [r14d_pkg::DW-1:0] file_wdata, // File write data
  input wire logic file_we // File write strobe
);
  import r14d_pkg::*;
  logic [IW-1:0] rom [0:63];
  logic [DW-1:0] ram [0:127];
  initial begin
    for (int i = 0; i < 64; i++) begin
      rom[i] = 14'h0000;
    end
    for (int i = 0; i < 128; i++) begin
      ram[i] = 8'h00;
    end
  end
  // The word and the operand answer at once, so they are valid in Q1 and Q3.
  assign prog_word = rom[prog_addr[5:0]];
  assign file_rdata = ram[file_addr];
  always @(posedge mclk) begin
    if (file_we === 1'b1) begin
      ram[file_addr] <= file_wdata;
    end
  end
endmodule
`default_nettype wire

// >>> tb_top.sv
// Self-checking bench that runs a short program through the core.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import r14d_pkg::*;
  logic mclk;
  logic resetn;
  logic [PC_W-1:0] prog_addr;
  logic [IW-1:0] prog_word;
  logic [FA_W-1:0] file_addr;
  logic [DW-1:0] file_rdata;
  logic [DW-1:0] file_wdata;
  logic [DW-1:0] port_pins;
  logic [DW-1:0] acc;
  logic file_we, presc_on_timer, presc_clear, wdt_clear, wake, standby;
  logic cf, dcf, zf, tof, pdf;
  int n_mismatch, n_checks, n_presc, n_wdt, c;

  r14d_core r14d_core_inst (.mclk(mclk), .resetn(resetn),
    .prog_addr(prog_addr), .prog_word(prog_word), .file_addr(file_addr),
    .file_rdata(file_rdata), .file_wdata(file_wdata), .file_we(file_we),
    .port_pins(port_pins), .presc_on_timer(presc_on_timer),
    .presc_clear(presc_clear), .wdt_clear(wdt_clear), .wake(wake),
    .standby(standby), .main_accumulator(acc), .ninth_bit_flag(cf),
    .digit_carry(dcf), .result_null_flag(zf), .expiry_flag(tof),
    .powerdown_flag(pdf));

  r14d_mem_model r14d_mem_model_inst (.mclk(mclk), .prog_addr(prog_addr),
    .prog_word(prog_word), .file_addr(file_addr), .file_rdata(file_rdata),
    .file_wdata(file_wdata), .file_we(file_we));

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    if (presc_clear === 1'b1) n_presc++;
    if (wdt_clear === 1'b1) n_wdt++;
  end

  function automatic logic [13:0] bw(logic [3:0] o, logic d, logic [6:0] f);
    return {2'b00, o, d, f};
  endfunction
  function automatic logic [13:0] lw(logic [3:0] o, logic [7:0] k);
    return {2'b11, o, k};
  endfunction
  function automatic logic [13:0] bt(logic [1:0] o, logic [2:0] b,
                                     logic [6:0] f);
    return {2'b01, o, b, f};
  endfunction

  task automatic ld(input int a, input logic [13:0] w);
    r14d_mem_model_inst.rom[a] = w;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t mismatch seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Counts falling edges until the core fetches from the given address.
  task automatic run_to(input logic [PC_W-1:0] a, output int n);
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (prog_addr !== a && n < 300);
    if (prog_addr !== a) begin
      n_mismatch++;
      tally_and_finish();
    end
  endtask

  function automatic logic [15:0] rd(logic [6:0] f);
    return {8'h00, r14d_mem_model_inst.ram[f]};
  endfunction

  initial begin
    resetn = 1'b0;
    wake = 1'b0;
    presc_on_timer = 1'b1;
    port_pins = 8'ha5;
    #1;
    ld(0, lw(4'h0, 8'h5a)); ld(1, lw(4'ha, 8'h5a)); ld(2, lw(4'h8, 8'h81));
    ld(3, bw(4'h0, 1'b1, 7'h20)); ld(4, bw(4'hd, 1'b1, 7'h20));
    ld(5, bw(4'hc, 1'b0, 7'h20)); ld(6, bw(4'h6, 1'b1, 7'h20));
    ld(7, bw(4'h4, 1'b0, 7'h21)); ld(8, lw(4'h0, 8'h01));
    ld(9, bw(4'hb, 1'b1, 7'h22)); ld(10, lw(4'h0, 8'hee));
    ld(11, bw(4'hf, 1'b1, 7'h23)); ld(12, lw(4'h0, 8'hdd));
    ld(13, bt(2'h2, 3'h3, 7'h24)); ld(14, lw(4'h0, 8'hcc));
    ld(15, bt(2'h3, 3'h2, 7'h24)); ld(16, lw(4'h0, 8'hbb));
    ld(17, lw(4'he, 8'h0f)); ld(18, bw(4'h0, 1'b1, 7'h25));
    ld(19, lw(4'hc, 8'h10)); ld(20, 14'h201e);
    ld(21, bw(4'h0, 1'b1, 7'h26)); ld(22, 14'h2828);
    ld(30, lw(4'h4, 8'h3c)); ld(40, bw(4'h0, 1'b1, 7'h01));
    ld(41, bw(4'h8, 1'b0, 7'h01)); ld(42, bw(4'h8, 1'b0, 7'h06));
    ld(43, bw(4'h0, 1'b1, 7'h27)); ld(44, 14'h0063);
    ld(45, 14'h0064);
    r14d_mem_model_inst.ram[7'h06] = 8'h11;
    r14d_mem_model_inst.ram[7'h21] = 8'h0c;
    r14d_mem_model_inst.ram[7'h22] = 8'h01;
    r14d_mem_model_inst.ram[7'h23] = 8'hff;
    r14d_mem_model_inst.ram[7'h24] = 8'hf7;
    repeat (8) @(posedge mclk);
    resetn <= 1'b1;
    run_to(13'h0, c);
    run_to(13'h1, c);
    chk(16'(c), 16'h4);
    run_to(13'h2, c);
    chk(acc, 8'h00);
    chk(zf, 1'b1);
    run_to(13'h3, c);
    chk(acc, 8'h81);
    chk(zf, 1'b0);
    run_to(13'h5, c);
    chk(cf, 1'b1);
    run_to(13'h6, c);
    chk(acc, 8'h81);
    chk(cf, 1'b0);
    chk(rd(7'h20), 8'h02);
    run_to(13'h8, c);
    chk(acc, 8'h8d);
    run_to(13'h9, c);
    run_to(13'hb, c);
    chk(16'(c), 16'h4);
    run_to(13'hd, c);
    chk(16'(c), 16'h8);
    run_to(13'hf, c);
    chk(16'(c), 16'h8);
    run_to(13'h11, c);
    chk(16'(c), 16'h8);
    chk(acc, 8'h01);
    run_to(13'h12, c);
    chk(16'(c), 16'h8);
    chk({acc, 5'h0, cf, dcf, zf}, 16'h1002);
    run_to(13'h14, c);
    chk({acc, 5'h0, cf, dcf, zf}, 16'h0007);
    run_to(13'h1e, c);
    chk(16'(c), 16'h4);
    run_to(13'h15, c);
    chk(16'(c), 16'h8);
    chk(acc, 8'h3c);
    run_to(13'h2d, c);
    chk({standby, tof, pdf}, 3'h6);
    chk(wdt_clear, 1'b1);
    chk(acc, 8'ha5);
    chk(16'(n_presc), 16'h1);
    chk(rd(7'h20), 8'h83);
    chk(rd(7'h22), 8'h00);
    chk(rd(7'h23), 8'h00);
    chk(rd(7'h25), 8'h10);
    chk(rd(7'h26), 8'h3c);
    chk(rd(7'h27), 8'ha5);
    @(posedge mclk);
    wake <= 1'b1;
    c = 0;
    while (standby !== 1'b0 && c < 20) begin
      @(negedge mclk);
      c++;
    end
    chk(standby, 1'b0);
    run_to(13'h2e, c);
    chk({standby, tof, pdf}, 3'h3);
    chk(wdt_clear, 1'b1);
    @(negedge mclk);
    chk(16'(n_wdt), 16'h2);
    tally_and_finish();
  end
endmodule
`default_nettype wire
